//--- rtl/pin_remap_consts.svh
`ifndef PIN_REMAP_CONSTS_SVH
`define PIN_REMAP_CONSTS_SVH

// register byte offsets
`define OFS_DIRECTION 12'h000
`define OFS_LATCH 12'h004
`define OFS_PIN_LEVEL 12'h008
`define OFS_SPI2_INSEL 12'h00C
`define OFS_OUTMAP_BASE 12'h040

// reset values
`define DIRECTION_RESET 32'hFFFF_FFFF
`define SPI2_INSEL_RESET 16'h0000
`define OUTSEL_RESET 6'h00

// spi2 input select fields
`define CLKSEL_LSB 8
`define DATSEL_LSB 0
`define INSEL_MASK 32'h0000_7F7F

// output selector codes
`define OSEL_NULL 6'h00
`define OSEL_SER1_TX 6'h01
`define OSEL_SER2_TX 6'h03
`define OSEL_SPIB_DO 6'h08
`define OSEL_SPIB_CK 6'h09
`define OSEL_SPIB_SS 6'h0A
`define OSEL_CANA_TX 6'h0E
`define OSEL_OC_A 6'h10
`define OSEL_OC_B 6'h11
`define OSEL_OC_C 6'h12
`define OSEL_OC_D 6'h13
`define OSEL_CMP_A 6'h18
`define OSEL_CMP_B 6'h19
`define OSEL_CMP_C 6'h1A
`define OSEL_TB_SYNC 6'h2D
`define OSEL_POS_CMP 6'h2F
`define OSEL_REFCLK 6'h31
`define OSEL_CMP_D 6'h32

// input selector: code of pin 0; code 0 ties low
`define ISEL_PIN_BASE 7'h28

`endif

//--- rtl/pin_remap_pkg.sv
package pin_remap_pkg;
    // remappable peripheral outputs
    typedef struct packed {
        logic serial1_transmit;
        logic serial2_transmit;
        logic spi_b_data_out;
        logic spi_b_clock_out;
        logic spi_b_select_out;
        logic can_a_transmit;
        logic [3:0] compare_out;
        logic [3:0] comparator_out;
        logic timebase_sync_out;
        logic position_counter_compare_out;
        logic reference_clock_out;
    } periph_out_t;
    // remapped peripheral inputs
    typedef struct packed {
        logic spi_b_clock_in;
        logic spi_b_data_in;
    } periph_in_t;
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
endpackage : pin_remap_pkg

//--- rtl/port_and_pin_remap.sv
`timescale 1ns/1ns
`default_nettype none
`include "pin_remap_consts.svh"

module port_and_pin_remap #(
    parameter int NUM_PINS = 16,
    parameter logic [31:0] VALID_MASK = 32'h0000_FFFF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register bus
    input wire pin_remap_pkg::apb_req_t apb_req,
    output pin_remap_pkg::apb_rsp_t apb_rsp,
    // pins
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe,
    // peripherals
    input wire pin_remap_pkg::periph_out_t periph_out,
    input wire logic [NUM_PINS-1:0] periph_active,
    output pin_remap_pkg::periph_in_t periph_in
);
    import pin_remap_pkg::*;

    // refuse widths the 32-bit registers cannot hold
    if (NUM_PINS < 1 || NUM_PINS > 32) begin : g_bad_width
        $error("NUM_PINS must be 1 to 32");
    end

    localparam logic [31:0] PMASK = VALID_MASK & ((NUM_PINS == 32) ? 32'hFFFF_FFFF :
        ((32'h0000_0001 << NUM_PINS) - 32'h0000_0001));

    ////////////////////////////////////////////////////////////////////////////
    // pin input synchroniser
    logic [NUM_PINS-1:0] pin_meta_q;
    logic [NUM_PINS-1:0] pin_sync_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [NUM_PINS-1:0] dir_q;
    logic [NUM_PINS-1:0] lat_q;
    logic [6:0] clk_insel_q;
    logic [6:0] dat_insel_q;
    logic [5:0] outsel_q [NUM_PINS];
    apb_rsp_t rsp_q;

    logic access;
    logic wr;
    logic [11:0] addr;
    assign access = apb_req.psel && apb_req.penable;
    assign wr = access && apb_req.pwrite;
    assign addr = apb_req.paddr;

    logic [31:0] level_masked;
    assign level_masked = 32'(pin_sync_q) & PMASK;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dir_q <= NUM_PINS'(`DIRECTION_RESET);
        end else if (wr && addr == `OFS_DIRECTION) begin
            dir_q <= NUM_PINS'(apb_req.pwdata) | ~NUM_PINS'(PMASK);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            lat_q <= '0;
        end else if (wr && (addr == `OFS_LATCH || addr == `OFS_PIN_LEVEL)) begin
            lat_q <= NUM_PINS'(apb_req.pwdata & PMASK);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            clk_insel_q <= 7'h00;
            dat_insel_q <= 7'h00;
        end else if (wr && addr == `OFS_SPI2_INSEL) begin
            clk_insel_q <= apb_req.pwdata[`CLKSEL_LSB +: 7];
            dat_insel_q <= apb_req.pwdata[`DATSEL_LSB +: 7];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_outsel
            // one word per pin, no cross
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    outsel_q[gi] <= `OUTSEL_RESET;
                end else if (wr && addr == `OFS_OUTMAP_BASE + 12'(gi * 4)) begin
                    outsel_q[gi] <= apb_req.pwdata[5:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read path, one wait-free access cycle
    logic [31:0] rdata;
    logic hit;
    always_comb begin
        rdata = 32'h0000_0000;
        hit = 1'b1;
        if (addr == `OFS_DIRECTION) begin
            rdata = 32'(dir_q) & PMASK;
        end else if (addr == `OFS_LATCH) begin
            rdata = 32'(lat_q) & PMASK;
        end else if (addr == `OFS_PIN_LEVEL) begin
            rdata = level_masked;
        end else if (addr == `OFS_SPI2_INSEL) begin
            rdata = {17'h0, clk_insel_q, 1'b0, dat_insel_q} & `INSEL_MASK;
        end else begin
            hit = 1'b0;
            for (int i = 0; i < NUM_PINS; i++) begin
                if (addr == `OFS_OUTMAP_BASE + 12'(i * 4)) begin
                    rdata = {26'h0, outsel_q[i]};
                    hit = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rsp_q <= '0;
        end else begin
            rsp_q.pready <= apb_req.psel && !apb_req.penable;
            rsp_q.pslverr <= apb_req.psel && !apb_req.penable && !hit;
            rsp_q.prdata <= (apb_req.psel && !apb_req.penable && !apb_req.pwrite) ?
                rdata : 32'h0000_0000;
        end
    end
    assign apb_rsp = rsp_q;

    ////////////////////////////////////////////////////////////////////////////
    // output selection per pin
    function automatic logic [1:0] route(input logic [5:0] sel, input periph_out_t po);
        logic [1:0] r;
        r = 2'b00;
        case (sel)
            `OSEL_SER1_TX: r = {1'b1, po.serial1_transmit};
            `OSEL_SER2_TX: r = {1'b1, po.serial2_transmit};
            `OSEL_SPIB_DO: r = {1'b1, po.spi_b_data_out};
            `OSEL_SPIB_CK: r = {1'b1, po.spi_b_clock_out};
            `OSEL_SPIB_SS: r = {1'b1, po.spi_b_select_out};
            `OSEL_CANA_TX: r = {1'b1, po.can_a_transmit};
            `OSEL_OC_A: r = {1'b1, po.compare_out[0]};
            `OSEL_OC_B: r = {1'b1, po.compare_out[1]};
            `OSEL_OC_C: r = {1'b1, po.compare_out[2]};
            `OSEL_OC_D: r = {1'b1, po.compare_out[3]};
            `OSEL_CMP_A: r = {1'b1, po.comparator_out[0]};
            `OSEL_CMP_B: r = {1'b1, po.comparator_out[1]};
            `OSEL_CMP_C: r = {1'b1, po.comparator_out[2]};
            `OSEL_CMP_D: r = {1'b1, po.comparator_out[3]};
            `OSEL_TB_SYNC: r = {1'b1, po.timebase_sync_out};
            `OSEL_POS_CMP: r = {1'b1, po.position_counter_compare_out};
            `OSEL_REFCLK: r = {1'b1, po.reference_clock_out};
            default: r = 2'b00; // null and unused codes
        endcase
        return r;
    endfunction

    logic [NUM_PINS-1:0] own_q;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            logic [1:0] rt;
            logic periph_owns;
            assign rt = route(outsel_q[gi], periph_out);
            // peripheral owns only while mapped and driving
            assign periph_owns = rt[1] && periph_active[gi];
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    pin_out[gi] <= 1'b0;
                    pin_oe[gi] <= 1'b0;
                    own_q[gi] <= 1'b0;
                end else if (!PMASK[gi]) begin
                    pin_out[gi] <= 1'b0;
                    pin_oe[gi] <= 1'b0;
                    own_q[gi] <= 1'b0;
                end else begin
                    // mux pair for data and enable
                    pin_out[gi] <= periph_owns ? rt[0] : lat_q[gi];
                    pin_oe[gi] <= periph_owns ? 1'b1 : !dir_q[gi];
                    own_q[gi] <= periph_owns;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // input selection
    function automatic logic pick(input logic [6:0] sel, input logic [NUM_PINS-1:0] lv,
                                  input logic [NUM_PINS-1:0] port_drv);
        logic v;
        v = 1'b0; // zero ties low
        for (int i = 0; i < NUM_PINS; i++) begin
            // unmapped codes match no pin
            if (sel == `ISEL_PIN_BASE + 7'(i) && PMASK[i]) begin
                // suppress loop-through from the port's own driver
                v = port_drv[i] ? 1'b0 : lv[i];
            end
        end
        return v;
    endfunction

    logic [NUM_PINS-1:0] port_drv;
    assign port_drv = ~dir_q & ~own_q;

    // drive history spans pad register plus synchroniser delay
    logic [NUM_PINS-1:0] drv_h1_q;
    logic [NUM_PINS-1:0] drv_h2_q;
    logic [NUM_PINS-1:0] drv_h3_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            drv_h1_q <= '0;
            drv_h2_q <= '0;
            drv_h3_q <= '0;
        end else begin
            drv_h1_q <= port_drv;
            drv_h2_q <= drv_h1_q;
            drv_h3_q <= drv_h2_q;
        end
    end

    // no stale port level leaks through after the port lets go
    logic [NUM_PINS-1:0] loop_mask;
    assign loop_mask = port_drv | drv_h1_q | drv_h2_q | drv_h3_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            periph_in <= '0;
        end else begin
            periph_in.spi_b_clock_in <= pick(clk_insel_q, pin_sync_q, loop_mask);
            periph_in.spi_b_data_in <= pick(dat_insel_q, pin_sync_q, loop_mask);
        end
    end
endmodule : port_and_pin_remap
`default_nettype wire

//--- dv/pin_partner.sv
`timescale 1ns/1ns
`default_nettype none
module pin_partner #(
    parameter int NP = 16
) (
    // pad side
    input wire logic [NP-1:0] pin_out,
    input wire logic [NP-1:0] pin_oe,
    input wire logic [NP-1:0] ext_lvl,
    // sensed level
    output logic [NP-1:0] pin_in
);
    // driven pads show block data, released pads the board level
    assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule : pin_partner
`default_nettype wire

//--- dv/port_and_pin_remap_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "pin_remap_consts.svh"
module port_and_pin_remap_chk #(
    parameter int NUM_PINS = 16,
    parameter logic [31:0] VALID_MASK = 32'h0000_FFFF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // bus
    input wire pin_remap_pkg::apb_req_t apb_req,
    input wire pin_remap_pkg::apb_rsp_t apb_rsp,
    // pins and peripherals
    input wire logic [NUM_PINS-1:0] pin_in,
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe,
    input wire pin_remap_pkg::periph_out_t periph_out,
    input wire logic [NUM_PINS-1:0] periph_active,
    input wire pin_remap_pkg::periph_in_t periph_in
);
    import pin_remap_pkg::*;
    logic dir_q, lat_q, wr;
    logic [5:0] sel_q;
    logic [14:0] ins_q;
    assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    // shadow of pin 0 controls and of the spi2 input selects
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dir_q <= 1'b1;
            lat_q <= 1'b0;
            sel_q <= 6'h00;
            ins_q <= 15'h0000;
        end else if (wr) begin
            case (apb_req.paddr)
                `OFS_DIRECTION: dir_q <= apb_req.pwdata[0];
                `OFS_LATCH, `OFS_PIN_LEVEL: lat_q <= apb_req.pwdata[0];
                `OFS_SPI2_INSEL: ins_q <= apb_req.pwdata[14:0];
                `OFS_OUTMAP_BASE: sel_q <= apb_req.pwdata[5:0];
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    chk_reset_inputs: assert property (
        $rose(rst_b) |-> pin_oe == '0) else $error("pin enabled after reset");
    chk_owner_drives: assert property (
        sel_q == `OSEL_SER1_TX && periph_active[0] |=> pin_oe[0]
        && pin_out[0] == $past(periph_out.serial1_transmit)) else $error("owner not driving");
    chk_idle_port: assert property (
        sel_q == `OSEL_SER1_TX && !periph_active[0] |=> pin_oe[0] == !$past(dir_q)
        && pin_out[0] == $past(lat_q)) else $error("idle owner blocks port");
    chk_null_port: assert property (
        sel_q == `OSEL_NULL |=> pin_oe[0] == !$past(dir_q)
        && pin_out[0] == $past(lat_q)) else $error("port control wrong");
    chk_invalid_zero: assert property (
        apb_rsp.pready && !apb_req.pwrite && apb_req.paddr <= `OFS_PIN_LEVEL
        |-> (apb_rsp.prdata & ~VALID_MASK) == '0) else $error("invalid bits read set");
    chk_insel_gaps: assert property (
        apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == `OFS_SPI2_INSEL
        |-> (apb_rsp.prdata & ~`INSEL_MASK) == '0) else $error("select gap bits set");
    chk_no_loop: assert property (
        (!dir_q && sel_q == `OSEL_NULL && ins_q[6:0] == `ISEL_PIN_BASE)[*5]
        |-> !periph_in.spi_b_data_in) else $error("port output loops back");
    chk_zero_low: assert property (
        (ins_q[14:8] == 7'h00)[*5] |-> !periph_in.spi_b_clock_in) else $error("zero select not low");
    cover property (periph_active[0] && sel_q == `OSEL_SER1_TX);
    cover property (apb_rsp.pslverr);
    cover property (!dir_q && ins_q[6:0] == `ISEL_PIN_BASE);
endmodule : port_and_pin_remap_chk
`default_nettype wire

//--- dv/port_and_pin_remap_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pin_remap_consts.svh"
module port_and_pin_remap_tb;
    import pin_remap_pkg::*;
    localparam int NP = 16;
    // top pin invalid on this variant
    localparam logic [31:0] VM = 32'h0000_7FFF;
    logic clk_sys, rst_b, err;
    apb_req_t apb_req;
    apb_rsp_t apb_rsp;
    logic [NP-1:0] pin_in, pin_out, pin_oe, periph_active, ext_lvl;
    periph_out_t periph_out;
    periph_in_t periph_in;
    logic [31:0] rd;
    int bad_count, checked, cycles;
    logic [5:0] codes [17] = '{`OSEL_SER1_TX, `OSEL_SER2_TX, `OSEL_SPIB_DO, `OSEL_SPIB_CK,
        `OSEL_SPIB_SS, `OSEL_CANA_TX, `OSEL_OC_A, `OSEL_OC_B, `OSEL_OC_C, `OSEL_OC_D,
        `OSEL_CMP_A, `OSEL_CMP_B, `OSEL_CMP_C, `OSEL_CMP_D, `OSEL_TB_SYNC, `OSEL_POS_CMP,
        `OSEL_REFCLK};
    int bits [17] = '{16, 15, 14, 13, 12, 11, 7, 8, 9, 10, 3, 4, 5, 6, 2, 1, 0};
    port_and_pin_remap #(.NUM_PINS(NP), .VALID_MASK(VM)) DUT (.clk_sys(clk_sys), .rst_b(rst_b),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .periph_out(periph_out), .periph_active(periph_active),
        .periph_in(periph_in));
    pin_partner #(.NP(NP)) u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
        .pin_in(pin_in));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////
    task summarize;
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        apb_req.paddr <= a;
        apb_req.pwrite <= w;
        apb_req.pwdata <= d;
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge clk_sys);
    endtask : xfer
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        check(rd, exp);
    endtask : rdchk
    ////////////////////////////////////////////////////////////////
    initial begin
        bad_count = 0;
        checked = 0;
        cycles = 0;
        rst_b = 1'b0;
        apb_req = '0;
        periph_out = '0;
        periph_active = '0;
        ext_lvl = 16'hF0F0;
        tick(2);
        rst_b <= 1'b1;
        check(32'(pin_oe), 32'h0000_0000);
        rdchk(`OFS_DIRECTION, `DIRECTION_RESET & VM);
        rdchk(`OFS_SPI2_INSEL, 32'h0000_0000);
        rdchk(`OFS_OUTMAP_BASE, 32'h0000_0000);
        xfer(12'h0FC, 1'b0, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
        xfer(`OFS_LATCH, 1'b1, 32'hFFFF_A5A5);
        rdchk(`OFS_LATCH, 32'h0000_25A5);
        xfer(`OFS_PIN_LEVEL, 1'b1, 32'h0000_5A5A);
        rdchk(`OFS_LATCH, 32'h0000_5A5A);
        xfer(`OFS_DIRECTION, 1'b1, 32'h0000_7F00);
        rdchk(`OFS_DIRECTION, 32'h0000_7F00);
        tick(4);
        check(32'(pin_oe), 32'h0000_00FF);
        check(32'(pin_out & pin_oe), 32'h0000_005A);
        rdchk(`OFS_PIN_LEVEL, 32'h0000_705A);
        xfer(`OFS_DIRECTION, 1'b1, 32'h0000_FFFF);
        periph_active <= 16'h0001;
        for (int i = 0; i < 17; i++) begin
            xfer(`OFS_OUTMAP_BASE, 1'b1, 32'(codes[i]));
            rdchk(`OFS_OUTMAP_BASE, 32'(codes[i]));
            periph_out <= periph_out_t'(17'h1 << bits[i]);
            tick(2);
            check(32'({pin_oe[0], pin_out[0]}), 32'h3);
            periph_out <= periph_out_t'(~(17'h1 << bits[i]));
            tick(2);
            check(32'({pin_oe[0], pin_out[0]}), 32'h2);
        end
        periph_out <= '1;
        tick(4);
        rdchk(`OFS_PIN_LEVEL, 32'h0000_70F1);
        // one source on two pins, no other driver on those pads
        xfer(`OFS_OUTMAP_BASE, 1'b1, 32'(`OSEL_SER1_TX));
        xfer(12'h044, 1'b1, 32'(`OSEL_SER1_TX));
        periph_active <= 16'h0003;
        periph_out <= periph_out_t'(17'h1_0000);
        tick(2);
        check(32'(pin_out[1:0] & pin_oe[1:0]), 32'h3);
        periph_active <= '0;
        xfer(`OFS_DIRECTION, 1'b1, 32'h0000_FFFE);
        xfer(`OFS_LATCH, 1'b1, 32'h0000_0001);
        tick(2);
        check(32'({pin_oe[1:0], pin_out[0]}), 32'h3);
        xfer(`OFS_OUTMAP_BASE, 1'b1, 32'h0000_0000);
        xfer(12'h044, 1'b1, 32'h0000_0000);
        xfer(`OFS_DIRECTION, 1'b1, 32'h0000_FFFF);
        ext_lvl <= 16'h0003;
        // clock from pin 1, data from pin 0
        xfer(`OFS_SPI2_INSEL, 1'b1, 32'h0000_2928);
        tick(5);
        check(32'(periph_in), 32'h3);
        xfer(`OFS_SPI2_INSEL, 1'b1, 32'h0000_0062);
        tick(5);
        check(32'(periph_in), 32'h0);
        xfer(`OFS_SPI2_INSEL, 1'b1, 32'hFFFF_FFFF);
        rdchk(`OFS_SPI2_INSEL, `INSEL_MASK);
        xfer(`OFS_SPI2_INSEL, 1'b1, 32'h0000_0028);
        ext_lvl <= '0;
        xfer(`OFS_DIRECTION, 1'b1, 32'h0000_FFFE);
        tick(6);
        check(32'(periph_in), 32'h0);
        rdchk(`OFS_PIN_LEVEL, 32'h0000_0001);
        // second reset while pin 0 is driven
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        check(32'(pin_oe), 32'h0000_0000);
        rdchk(`OFS_DIRECTION, `DIRECTION_RESET & VM);
        rdchk(`OFS_OUTMAP_BASE, 32'h0000_0000);
        summarize();
    end
endmodule : port_and_pin_remap_tb
bind port_and_pin_remap port_and_pin_remap_chk #(.NUM_PINS(NUM_PINS), .VALID_MASK(VALID_MASK))
    u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
    .periph_active(periph_active), .periph_in(periph_in));
`default_nettype wire
